/* src/drs_pkg.sv */
// constants for the loop status and holdover register slice
package drs_pkg;
  localparam int unsigned DRS_AW        = 10;     // byte address width
  localparam int unsigned DRS_DW        = 32;     // bus data width
  localparam int unsigned DRS_BEW       = 4;      // byte enable width
  localparam int unsigned DRS_IW        = 8;      // register index width
  localparam int unsigned DRS_IDX_LSB   = 2;      // byte address = 4*index
  localparam logic [7:0]  DRS_IDX_HO_B2 = 8'h94;  // holdover bits 23:16
  localparam logic [7:0]  DRS_IDX_HO_B3 = 8'h95;  // holdover bits 31:24
  localparam logic [7:0]  DRS_IDX_PRI_L = 8'h96;  // best / chosen input
  localparam logic [7:0]  DRS_IDX_PRI_H = 8'h97;  // third / second input
  localparam logic [7:0]  DRS_IDX_PH_LO = 8'h98;  // phase bits 7:0
  localparam logic [7:0]  DRS_IDX_PH_HI = 8'h99;  // phase bits 15:8
  localparam logic [7:0]  DRS_IDX_BANK  = 8'h9F;  // loop_bank_select
  localparam int unsigned DRS_CW        = 4;      // input code width
  localparam logic [3:0]  DRS_CODE_NONE = 4'h0;   // no input reported
  localparam logic [3:0]  DRS_CODE_MAX  = 4'h8;   // input_clock_eight
  localparam logic [3:0]  DRS_CODE_ONE  = 4'h1;   // input_clock_one
  localparam int unsigned DRS_NIN       = 8;      // number of inputs
  localparam int unsigned DRS_HSW       = 2;      // holdover_select width
  localparam logic [1:0]  DRS_HO_MANUAL = 2'h1;   // manual holdover mode
  localparam int unsigned DRS_PHW       = 16;     // phase readout width
  localparam int unsigned DRS_HOW       = 16;     // upper holdover half
  localparam logic [7:0]  DRS_BYTE_RST  = 8'h00;  // byte reset value
  localparam logic [31:0] DRS_WORD_RST  = 32'h0000_0000; // bus word reset
endpackage

/* src/drs_loop_regs.sv */
// per-loop holdover and reference status registers on an avalon slave
`timescale 1ns/10ps
// Overview of operation
// - accesses go to bank chosen by selector
// - holdover bits 23:16 at 94h, 31:24 at 95h
// - best valid input in 96h bits 7:4
// - codes one to eight only, never above
// - chosen input in 96h bits 3:0
// - inputs marked invalid never reported
// - chosen may differ from best, not forced
// - second valid input in 97h bits 3:0
// - third valid input in 97h bits 7:4
// - signed 16-bit phase at 98h and 99h
// - one phase count is 0.707 degrees
// - holdover word used when select is 01
module drs_loop_regs
  import drs_pkg::*;
#(
  parameter int unsigned NL = 2                    // number of loops
)(
  input  wire logic                   clk,                   // 250 MHz clock
  input  wire logic                   rst_b,                 // sync reset
  input  wire logic [DRS_AW-1:0]      avs_address,           // byte address
  input  wire logic                   avs_read,              // read request
  input  wire logic                   avs_write,             // write request
  input  wire logic [DRS_DW-1:0]      avs_writedata,         // write data
  input  wire logic [DRS_BEW-1:0]     avs_byteenable,        // byte lanes
  output logic      [DRS_DW-1:0]      avs_readdata,          // read data
  output logic                        avs_waitrequest,       // stall
  input  wire logic [NL*DRS_CW-1:0]   best_valid_input,      // per loop
  input  wire logic [NL*DRS_CW-1:0]   current_chosen_input,  // per loop
  input  wire logic [NL*DRS_CW-1:0]   second_valid_input,    // per loop
  input  wire logic [NL*DRS_CW-1:0]   third_valid_input,     // per loop
  input  wire logic [DRS_NIN-1:0]     input_validation_ctrl, // 1 = valid
  input  wire logic [NL*DRS_PHW-1:0]  phase_avg,             // per loop
  input  wire logic [NL*DRS_HSW-1:0]  holdover_select,       // per loop
  output logic      [NL*DRS_HOW-1:0]  holdover_offset_word_hi, // bits 31:16
  output logic      [NL-1:0]          holdover_manual_en     // per loop
);

  // selector width: one bit more than the loop count needs, so that a
  // bank number past the last loop, up to 2**LSW - 1, is held and refused, not aliased
  // onto a real loop where a stray write would corrupt its holdover
  localparam int unsigned LSW = $clog2(NL) + 1;

  // all state of the block
  typedef struct packed {
    logic                         ack;    // answer cycle flag
    logic [DRS_DW-1:0]            rdata;  // registered read data
    logic [LSW-1:0]               sel;    // loop_bank_select
    logic [NL-1:0][7:0]           stage;  // staged bits 23:16
    logic [NL-1:0][DRS_HOW-1:0]   hold;   // applied bits 31:16
    logic [NL-1:0][7:0]           ph_hi;  // phase high snapshot
    logic [NL-1:0]                man;    // manual holdover active
  } drs_state_s;

  drs_state_s st_ff;   // registered state
  drs_state_s nxt_st;  // next state

  // cleaned per-loop status codes, and the raw phase
  logic [NL-1:0][DRS_CW-1:0]  best_c;    // best valid input
  logic [NL-1:0][DRS_CW-1:0]  chos_c;    // chosen input
  logic [NL-1:0][DRS_CW-1:0]  sec_c;     // second valid input
  logic [NL-1:0][DRS_CW-1:0]  thr_c;     // third valid input
  logic [NL-1:0][DRS_PHW-1:0] phase_a;   // phase per loop

  // bus decode
  logic [DRS_IW-1:0] idx;       // register index
  logic              req;       // any request
  logic              rd_take;   // read sampled into rdata
  logic              wr_acc;    // write accepted this edge
  logic              bank_ok;   // selector names a real loop
  logic [DRS_DW-1:0] rd_mux;    // read value

  // returns a code only if it names an existing, valid input
  function automatic logic [DRS_CW-1:0] drs_clean
  (
    input logic [DRS_CW-1:0]  code,
    input logic [DRS_NIN-1:0] valid
  );
    logic [2:0] pos;
    pos = 3'(code - DRS_CODE_ONE);
    if (code == DRS_CODE_NONE || code > DRS_CODE_MAX)
    begin
      drs_clean = DRS_CODE_NONE;
    end
    else if (!valid[pos])
    begin
      drs_clean = DRS_CODE_NONE;
    end
    else
    begin
      drs_clean = code;
    end
  endfunction

  // slice the flat per-loop ports and clean every status field
  generate
    for (genvar g = 0; g < NL; g++)
    begin : g_loop
      assign best_c[g] = drs_clean(best_valid_input[g*DRS_CW +: DRS_CW],
                                   input_validation_ctrl);
      // chosen is cleaned like the rest; no match to best is forced
      assign chos_c[g] = drs_clean(current_chosen_input[g*DRS_CW +: DRS_CW],
                                   input_validation_ctrl);
      assign sec_c[g]  = drs_clean(second_valid_input[g*DRS_CW +: DRS_CW],
                                   input_validation_ctrl);
      assign thr_c[g]  = drs_clean(third_valid_input[g*DRS_CW +: DRS_CW],
                                   input_validation_ctrl);
      assign phase_a[g] = phase_avg[g*DRS_PHW +: DRS_PHW];
      assign holdover_offset_word_hi[g*DRS_HOW +: DRS_HOW] = st_ff.hold[g];
    end
  endgenerate

  // request decode; each request waits exactly one cycle
  always_comb
  begin
    idx     = avs_address[DRS_IDX_LSB +: DRS_IW];
    req     = avs_read | avs_write;
    rd_take = avs_read & ~st_ff.ack;
    wr_acc  = avs_write & st_ff.ack;
    bank_ok = (32'(st_ff.sel) < NL);
  end

  assign avs_waitrequest    = req & ~st_ff.ack;
  assign avs_readdata       = st_ff.rdata;
  assign holdover_manual_en = st_ff.man;

  // read multiplexer; loop registers answer only for a real bank
  always_comb
  begin
    rd_mux = DRS_WORD_RST;
    if (idx == DRS_IDX_BANK)
    begin
      rd_mux[LSW-1:0] = st_ff.sel;
    end
    else if (bank_ok)
    begin
      case (idx)
        DRS_IDX_HO_B2: rd_mux[7:0] = st_ff.hold[st_ff.sel][7:0];
        DRS_IDX_HO_B3: rd_mux[7:0] = st_ff.hold[st_ff.sel][15:8];
        DRS_IDX_PRI_L: rd_mux[7:0] = {best_c[st_ff.sel],
                                      chos_c[st_ff.sel]};
        DRS_IDX_PRI_H: rd_mux[7:0] = {thr_c[st_ff.sel],
                                      sec_c[st_ff.sel]};
        // scale is fixed upstream, 0.707 degrees per count
        DRS_IDX_PH_LO: rd_mux[7:0] = phase_a[st_ff.sel][7:0];
        DRS_IDX_PH_HI: rd_mux[7:0] = st_ff.ph_hi[st_ff.sel];
        default:       rd_mux      = DRS_WORD_RST;
      endcase
    end
  end

  // next state
  always_comb
  begin
    nxt_st     = st_ff;
    nxt_st.ack = req & ~st_ff.ack;
    for (int i = 0; i < NL; i++)
    begin
      // mode decode registered so the output is glitch free
      nxt_st.man[i] =
        (holdover_select[i*DRS_HSW +: DRS_HSW] == DRS_HO_MANUAL);
    end
    if (rd_take)
    begin
      nxt_st.rdata = rd_mux;
      // high byte caught in the same cycle as the low byte
      if (idx == DRS_IDX_PH_LO && bank_ok)
      begin
        nxt_st.ph_hi[st_ff.sel] = phase_a[st_ff.sel][15:8];
      end
    end
    if (wr_acc && avs_byteenable[0])
    begin
      if (idx == DRS_IDX_BANK)
      begin
        nxt_st.sel = avs_writedata[LSW-1:0];
      end
      else if (bank_ok && idx == DRS_IDX_HO_B2)
      begin
        // staged only; the loop sees it with the top byte
        nxt_st.stage[st_ff.sel] = avs_writedata[7:0];
      end
      else if (bank_ok && idx == DRS_IDX_HO_B3)
      begin
        nxt_st.hold[st_ff.sel] = {avs_writedata[7:0],
                                  st_ff.stage[st_ff.sel]};
      end
    end
  end

  // state register with synchronous reset
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      st_ff.ack   <= 1'b0;
      st_ff.rdata <= DRS_WORD_RST;
      st_ff.sel   <= '0;
      st_ff.stage <= '0;
      st_ff.hold  <= '0;
      st_ff.ph_hi <= '0;
      st_ff.man   <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // helper views for the checks below
  logic [DRS_CW-1:0]  chk_best;   // best of selected loop
  logic [DRS_CW-1:0]  chk_chos;   // chosen of selected loop
  logic [DRS_CW-1:0]  chk_sec;    // second of selected loop
  logic [DRS_CW-1:0]  chk_thr;    // third of selected loop
  logic [DRS_HOW-1:0] chk_hold;   // holdover of selected loop
  logic [7:0]         chk_phhi;   // live phase high byte
  logic               chk_mode0;  // loop 0 in manual mode
  logic [7:0]         chk_wbyte;  // write data low byte
  logic [7:0]         chk_stage;  // staged byte of selected loop

  always_comb
  begin
    chk_best  = bank_ok ? best_c[st_ff.sel] : DRS_CODE_NONE;
    chk_chos  = bank_ok ? chos_c[st_ff.sel] : DRS_CODE_NONE;
    chk_sec   = bank_ok ? sec_c[st_ff.sel] : DRS_CODE_NONE;
    chk_thr   = bank_ok ? thr_c[st_ff.sel] : DRS_CODE_NONE;
    chk_hold  = bank_ok ? st_ff.hold[st_ff.sel] : '0;
    chk_phhi  = bank_ok ? phase_a[st_ff.sel][15:8] : DRS_BYTE_RST;
    chk_stage = bank_ok ? st_ff.stage[st_ff.sel] : DRS_BYTE_RST;
    chk_mode0 = (holdover_select[DRS_HSW-1:0] == DRS_HO_MANUAL);
    chk_wbyte = avs_writedata[7:0];
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  a_bank_gate: assert property (
    rd_take && !bank_ok && idx != DRS_IDX_BANK |=> avs_readdata == '0)
    else $error("unselectable bank returned data");

  a_hold_read: assert property (
    rd_take && idx == DRS_IDX_HO_B3 |=> avs_readdata[7:0] ==
      $past(chk_hold[15:8]))
    else $error("holdover top byte readback wrong");

  a_hold_apply: assert property (
    wr_acc && avs_byteenable[0] && bank_ok && idx == DRS_IDX_HO_B3
      |=> chk_hold == {$past(chk_wbyte), $past(chk_stage)})
    else $error("holdover bytes not applied together");

  a_best_field: assert property (
    rd_take && idx == DRS_IDX_PRI_L |=> avs_readdata[7:4] ==
      $past(chk_best))
    else $error("best input field wrong");

  a_code_range: assert property (
    rd_take |=> avs_readdata[3:0] <= DRS_CODE_MAX &&
      avs_readdata[7:4] <= DRS_CODE_MAX || $past(idx) == DRS_IDX_HO_B2 ||
      $past(idx) == DRS_IDX_HO_B3 || $past(idx) == DRS_IDX_PH_LO ||
      $past(idx) == DRS_IDX_PH_HI)
    else $error("input code out of range");

  a_chosen_field: assert property (
    rd_take && idx == DRS_IDX_PRI_L |=> avs_readdata[3:0] ==
      $past(chk_chos))
    else $error("chosen input field wrong");

  a_invalid_hidden: assert property (
    bank_ok && chk_best != DRS_CODE_NONE |->
      input_validation_ctrl[3'(chk_best - DRS_CODE_ONE)])
    else $error("invalid input reported");

  a_second_field: assert property (
    rd_take && idx == DRS_IDX_PRI_H |=> avs_readdata[3:0] ==
      $past(chk_sec))
    else $error("second input field wrong");

  a_third_field: assert property (
    rd_take && idx == DRS_IDX_PRI_H |=> avs_readdata[7:4] ==
      $past(chk_thr))
    else $error("third input field wrong");

  // high byte must come from the low read's snapshot; the master
  // leaves one idle cycle between back-to-back requests
  a_phase_snap: assert property (
    rd_take && bank_ok && idx == DRS_IDX_PH_LO ##3
      rd_take && idx == DRS_IDX_PH_HI |=> avs_readdata[7:0] ==
      $past(chk_phhi, 4))
    else $error("phase high byte not coherent");

  a_manual_mode: assert property (
    ##1 1 |-> holdover_manual_en[0] == $past(chk_mode0))
    else $error("manual holdover enable wrong");

  a_wait_once: assert property (
    req && !st_ff.ack |=> !avs_waitrequest)
    else $error("request not answered after one cycle");

  // a write to the lower byte is staged and must not reach the loop
  a_stage_hidden: assert property (
    wr_acc && idx == DRS_IDX_HO_B2 |=> $stable(holdover_offset_word_hi))
    else $error("staged byte reached the loop early");

  // a write with lane 0 off changes neither staged nor applied bytes
  a_lane_gate: assert property (
    wr_acc && !avs_byteenable[0] |=> $stable(chk_stage) && $stable(chk_hold))
    else $error("write with lane 0 off took effect");

  // status registers are read only
  a_ro_ignored: assert property (
    wr_acc && idx == DRS_IDX_PRI_L |=> $stable(chk_stage) &&
      $stable(chk_hold) && $stable(st_ff.sel))
    else $error("write to a status register took effect");

  // the bank number written is the one that steers later accesses
  a_sel_store: assert property (
    wr_acc && avs_byteenable[0] && idx == DRS_IDX_BANK |=>
      st_ff.sel == $past(avs_writedata[LSW-1:0]))
    else $error("bank select not stored");

  // read data stands until the next read is taken
  a_rdata_hold: assert property (
    !rd_take |=> $stable(avs_readdata))
    else $error("read data changed without a read");

  // main scenarios: paired writes, paired reads, bank moves, mode
  c_hold_write: cover property (
    wr_acc && idx == DRS_IDX_HO_B2 ##3 wr_acc && idx == DRS_IDX_HO_B3);
  c_phase_pair: cover property (
    rd_take && idx == DRS_IDX_PH_LO ##3 rd_take && idx == DRS_IDX_PH_HI);
  c_bank_switch: cover property (
    wr_acc && idx == DRS_IDX_BANK ##2 rd_take && idx == DRS_IDX_PRI_L);
  c_bank_refused: cover property (rd_take && !bank_ok);
  c_manual_on: cover property ($rose(holdover_manual_en[0]));

endmodule

/* sim/drs_host_model.sv */
// host software model: avalon master for the loop register slice
`timescale 1ns/10ps
module drs_host_model
  import drs_pkg::*;
(
  input  wire logic              clk,             // bus clock
  output logic [DRS_AW-1:0]      avs_address,     // byte address
  output logic                   avs_read,        // read strobe
  output logic                   avs_write,       // write strobe
  output logic [DRS_DW-1:0]      avs_writedata,   // write data
  output logic [DRS_BEW-1:0]     avs_byteenable,  // byte lanes
  input  wire logic [DRS_DW-1:0] avs_readdata,    // read data
  input  wire logic              avs_waitrequest  // slave stall
);
  // idle bus at time zero
  initial
  begin
    avs_address    = '0;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = '0;
    avs_byteenable = '0;
  end

  // one transfer, held until waitrequest is seen low at an edge
  task automatic xfer(input logic wr, input logic [7:0] idx,
                      input logic [7:0] wd, input logic be0,
                      output logic ok);
    int n;
    ok = 1'b0;
    @(posedge clk);
    avs_address    <= {idx, 2'b00};
    avs_write      <= wr;
    avs_read       <= !wr;
    avs_writedata  <= {24'h00_0000, wd};
    avs_byteenable <= {3'h7, be0};
    // bounded wait so a stuck slave cannot hang the run
    for (n = 0; n < 64 && !ok; n++)
    begin
      @(posedge clk);
      ok = (avs_waitrequest === 1'b0);
    end
    avs_read      <= 1'b0;
    avs_write     <= 1'b0;
    // released data lines do not keep the last value
    avs_writedata <= ~avs_writedata;
  endtask
endmodule

/* sim/tb.sv */
// self-checking bench for the loop status and holdover slice
`timescale 1ns/10ps
module tb
  import drs_pkg::*;
;
  localparam int NL = 2;           // loops in this build
  logic              clk;          // 250 MHz clock
  logic              rst_b;        // sync reset
  logic [DRS_AW-1:0] avs_address;  // bus address
  logic              avs_read;     // bus read
  logic              avs_write;    // bus write
  logic [31:0]       avs_writedata;
  logic [3:0]        avs_byteenable;
  logic [31:0]       avs_readdata;
  logic              avs_waitrequest;
  logic [7:0]        best_valid_input, current_chosen_input;
  logic [7:0]        second_valid_input, third_valid_input;
  logic [7:0]        input_validation_ctrl;
  logic [31:0]       phase_avg;    // two loops of phase
  logic [3:0]        holdover_select;
  logic [31:0]       holdover_offset_word_hi;
  logic [1:0]        holdover_manual_en;
  int                errors;       // mismatches
  int                checks;       // comparisons
  logic [31:0]       expq[$];      // expected read data, oldest first
  logic [15:0]       ho[2];        // applied holdover halves

  drs_loop_regs #(.NL(NL)) dut (.clk(clk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .best_valid_input(best_valid_input),
    .current_chosen_input(current_chosen_input),
    .second_valid_input(second_valid_input),
    .third_valid_input(third_valid_input),
    .input_validation_ctrl(input_validation_ctrl),
    .phase_avg(phase_avg), .holdover_select(holdover_select),
    .holdover_offset_word_hi(holdover_offset_word_hi),
    .holdover_manual_en(holdover_manual_en));

  drs_host_model host (.clk(clk), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  // free-running clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // bus write; a timeout counts as a mismatch and ends the run
  task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                    input logic be0);
    logic ok;
    host.xfer(1'b1, idx, d, be0, ok);
    if (!ok)
    begin
      errors++;
      report_and_stop();
    end
  endtask

  // bus read; expectation is noted before the request goes out
  task automatic rd(input logic [7:0] idx, input logic [31:0] e);
    logic ok;
    expq.push_back(e);
    host.xfer(1'b0, idx, 8'h00, 1'b1, ok);
    if (!ok)
    begin
      errors++;
      report_and_stop();
    end
  endtask

  // what a status field may show: a valid code one..eight, else none
  function automatic logic [3:0] vis(input logic [3:0] c,
                                     input logic [7:0] v);
    return (c >= 4'h1 && c <= 4'h8 && v[c - 4'h1]) ? c : 4'h0;
  endfunction

  // watcher: each completed read takes the oldest note
  always @(posedge clk)
  begin
    if (rst_b === 1'b1 && avs_read === 1'b1 && avs_waitrequest === 1'b0)
      check(avs_readdata, expq.pop_front());
  end

  initial
  begin
    int b;
    int i;
    logic [7:0] a, c, bv, cv, sv, tv, vv;
    logic [31:0] pv;
    logic [1:0] hs;
    rst_b = 1'b0;
    {best_valid_input, current_chosen_input} = '0;
    {second_valid_input, third_valid_input} = '0;
    input_validation_ctrl = '0;
    phase_avg = '0;
    holdover_select = '0;
    errors = 0;
    checks = 0;
    ho = '{default: 16'h0000};
    void'($urandom(12));
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    // registers 94h to 99h read zero after reset
    for (i = 'h94; i <= 'h99; i++)
      rd(i[7:0], DRS_WORD_RST);
    // per-bank holdover staging, apply and readback; bank 2 is absent
    for (b = 0; b < 3; b++)
    begin
      a = $urandom;
      c = $urandom;
      wr(DRS_IDX_BANK, b[7:0], 1'b1);
      wr(DRS_IDX_HO_B2, a, 1'b1);
      @(negedge clk);
      check(holdover_offset_word_hi, {ho[1], ho[0]});
      wr(DRS_IDX_HO_B3, c, 1'b1);
      if (b < NL)
        ho[b] = {c, a};
      @(negedge clk);
      check(holdover_offset_word_hi, {ho[1], ho[0]});
      rd(DRS_IDX_HO_B2, (b < NL) ? {24'h0, a} : DRS_WORD_RST);
      rd(DRS_IDX_HO_B3, (b < NL) ? {24'h0, c} : DRS_WORD_RST);
      rd(DRS_IDX_BANK, {24'h0, b[7:0]});
    end
    // refused writes: lane 0 off, read-only place; then a read of an unmapped place
    wr(DRS_IDX_BANK, 8'h00, 1'b1);
    wr(DRS_IDX_HO_B2, 8'h3C, 1'b1);
    wr(DRS_IDX_HO_B2, 8'hC3, 1'b0);
    wr(DRS_IDX_HO_B3, 8'h5A, 1'b1);
    ho[0] = 16'h5A3C;
    @(negedge clk);
    check(holdover_offset_word_hi, {ho[1], ho[0]});
    wr(DRS_IDX_PRI_L, 8'hFF, 1'b1);
    rd(DRS_IDX_PRI_L, DRS_WORD_RST);
    rd(8'h10, DRS_WORD_RST);
    // every holdover mode on both loops
    for (i = 0; i < 4; i++)
    begin
      hs = i[1:0];
      @(posedge clk);
      holdover_select <= {hs, ~hs};
      @(negedge clk);
      @(negedge clk);
      check({30'h0, holdover_manual_en},
            {30'h0, hs == 2'h1, ~hs == 2'h1});
    end
    // status fields: every best-input code, random validity, both loops
    for (i = 0; i < 32; i++)
    begin
      b = i % 2;
      {bv, cv, sv, tv, vv} = {$urandom, $urandom};
      bv[4*b +: 4] = i[4:1];
      @(posedge clk);
      best_valid_input      <= bv;
      current_chosen_input  <= cv;
      second_valid_input    <= sv;
      third_valid_input     <= tv;
      input_validation_ctrl <= vv;
      wr(DRS_IDX_BANK, b[7:0], 1'b1);
      rd(DRS_IDX_PRI_L, {24'h0, vis(bv[4*b +: 4], vv),
                         vis(cv[4*b +: 4], vv)});
      rd(DRS_IDX_PRI_H, {24'h0, vis(tv[4*b +: 4], vv),
                         vis(sv[4*b +: 4], vv)});
    end
    // phase: high byte comes from the snapshot taken by the low read
    for (i = 0; i < 8; i++)
    begin
      b = i % 2;
      pv = $urandom;
      wr(DRS_IDX_BANK, b[7:0], 1'b1);
      @(posedge clk);
      phase_avg <= pv;
      rd(DRS_IDX_PH_LO, {24'h0, pv[16*b +: 8]});
      // changed at the completing edge so the high read is back to back
      phase_avg <= ~pv;
      rd(DRS_IDX_PH_HI, {24'h0, pv[16*b+8 +: 8]});
    end
    // second reset in mid-run clears the applied holdover word
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    check(holdover_offset_word_hi, DRS_WORD_RST);
    rd(DRS_IDX_HO_B3, DRS_WORD_RST);
    report_and_stop();
  end
endmodule
